// ### testbench/rea_reactive_accum_bench.sv
// self-checking bench for the reactive accumulation block
`timescale 1ns/1ps
`default_nettype none
module rea_reactive_accum_bench
    import rea_pkg::*;
;
    logic                              clk   = 1'h0;
    logic                              rst_b = 1'h0;
    logic [1:0]                        mode  = 2'h0;
    logic [1:0]                        conn  = 2'h0;
    logic                              stb   = 1'h0;
    logic [REA_PHASES-1:0][REA_DW-1:0] at    = '0;
    logic [REA_PHASES-1:0][REA_DW-1:0] af    = '0;
    logic [REA_PHASES-1:0][REA_DW-1:0] rt    = '0;
    logic [REA_PHASES-1:0][REA_DW-1:0] rf    = '0;
    logic [REA_PHASES-1:0][REA_DW-1:0] cur   = '0;
    logic [REA_PHASES-1:0][REA_AW-1:0] et, ef, pt, pf;
    logic [REA_PHASES-1:0][REA_DW-1:0] ac, acs;
    logic                              vld;
    logic [REA_PHASES-1:0][REA_DW-1:0] hist[$];
    int                                error_cnt = 0;
    int                                n_tests   = 0;
    int                                cyc       = 0;

    always #50 clk = ~clk;

    rea_reactive_accum DUT (.CLK_IN(clk), .RST_B_IN(rst_b), .REACTIVE_ACCUM_MODE_IN(mode),
        .CONNECTION_SELECT_IN(conn), .SAMPLE_STROBE_IN(stb), .ACTIVE_TOTAL_IN(at),
        .ACTIVE_FUND_IN(af), .REACTIVE_TOTAL_IN(rt), .REACTIVE_FUND_IN(rf), .CURRENT_IN(cur),
        .ENERGY_REG_TOTAL_OUT(et), .ENERGY_REG_FUND_OUT(ef), .ENERGY_PULSE_OUTPUT_TOTAL_OUT(pt),
        .ENERGY_PULSE_OUTPUT_FUND_OUT(pf), .ACCUM_CURRENT_OUT(ac),
        .ACCUM_CURRENT_SHIFTED_OUT(acs), .ACCUM_VALID_OUT(vld));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [REA_AW-1:0] e, input logic [REA_AW-1:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk

    // expected conditioned sample; 25 bits so the most negative value has a magnitude
    function automatic logic [REA_AW-1:0] cexp(input logic [1:0] m, input logic [REA_DW-1:0] r,
        input logic [REA_DW-1:0] a);
        logic [REA_AW-1:0] e;
        e = {r[REA_DW-1], r};
        if ((m == 2'h2 && a[REA_DW-1]) || (m == 2'h3 && r[REA_DW-1]))
            return -e;
        return e;
    endfunction : cexp

    // strobes stay two cycles apart, as the shifted read needs
    task automatic pulse();
        @(negedge clk) stb = 1'h1;
        chk("valid idle", 25'h0000000, {24'h000000, vld});
        hist.push_back(cur);
        @(negedge clk) stb = 1'h0;
        chk("valid", 25'h0000001, {24'h000000, vld});
    endtask : pulse

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic run_modes();
        rt = {24'h800000, 24'h000123, 24'hFFF000};
        at = {24'h000000, 24'hF00000, 24'h000010};
        rf = {24'h7FFFFF, 24'hFFFF00, 24'h000456};
        af = {24'hC00000, 24'h000005, 24'h800000};
        for (int m = 0; m < 4; m++)
        begin
            mode = m[1:0];
            pulse();
            for (int p = 0; p < REA_PHASES; p++)
            begin
                chk("total", cexp(mode, rt[p], at[p]), et[p]);
                chk("fund", cexp(mode, rf[p], af[p]), ef[p]);
                chk("pulse total", cexp(mode, rt[p], at[p]), pt[p]);
                chk("pulse fund", cexp(mode, rf[p], af[p]), pf[p]);
            end
        end
    endtask : run_modes

    task automatic run_conn();
        cur = {24'h00C003, 24'h00B002, 24'h00A001};
        for (int c = 0; c < 4; c++)
        begin
            conn = c[1:0];
            pulse();
            chk("current a", {1'h0, cur[0]}, {1'h0, ac[0]});
            chk("current b", (c == 1) ? 25'h0 : {1'h0, cur[1]}, {1'h0, ac[1]});
            chk("current c", {1'h0, cur[2]}, {1'h0, ac[2]});
        end
        conn = 2'h0;
    endtask : run_conn

    // runs past the pointer wrap; the last strobes switch to delta service
    task automatic run_shift();
        logic [REA_PHASES-1:0][REA_DW-1:0] old;
        logic [REA_AW-1:0]                 e;
        for (int k = 0; k < 70; k++)
        begin
            cur[0] = {8'h10, k[15:0]};
            conn   = (k < 60) ? 2'h0 : 2'h1;
            pulse();
            old = '0;
            if (hist.size() > 40)
                old = hist[hist.size()-41];
            for (int p = 0; p < REA_PHASES; p++)
            begin
                e = (conn == 2'h1 && p == 1) ? 25'h0000000 : {1'h0, old[p]};
                chk("shifted", e, {1'h0, acs[p]});
            end
        end
        conn = 2'h0;
    endtask : run_shift

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    initial
    begin
        repeat (20) @(negedge clk);
        rst_b = 1'h1;
        @(negedge clk);
        chk("reset energy", 25'h0000000, et[0]);
        chk("reset pulse", 25'h0000000, pf[2]);
        chk("reset shifted", 25'h0000000, {1'h0, acs[1]});
        run_modes();
        run_conn();
        run_shift();
        complete_run();
    end
endmodule : rea_reactive_accum_bench

bind rea_reactive_accum rea_reactive_accum_properties chk_i (.CLK_IN(CLK_IN),
    .RST_B_IN(RST_B_IN), .REACTIVE_ACCUM_MODE_IN(REACTIVE_ACCUM_MODE_IN),
    .CONNECTION_SELECT_IN(CONNECTION_SELECT_IN), .SAMPLE_STROBE_IN(SAMPLE_STROBE_IN),
    .ACTIVE_TOTAL_IN(ACTIVE_TOTAL_IN), .REACTIVE_TOTAL_IN(REACTIVE_TOTAL_IN),
    .CURRENT_IN(CURRENT_IN), .ENERGY_REG_TOTAL_OUT(ENERGY_REG_TOTAL_OUT),
    .ENERGY_PULSE_OUTPUT_TOTAL_OUT(ENERGY_PULSE_OUTPUT_TOTAL_OUT),
    .ACCUM_CURRENT_OUT(ACCUM_CURRENT_OUT));
`default_nettype wire

// ### testbench/rea_reactive_accum_properties.sv
// port-level checks of the reactive accumulation block
`timescale 1ns/1ps
`default_nettype none
module rea_reactive_accum_properties
    import rea_pkg::*;
(
    input wire logic                              CLK_IN,
    input wire logic                              RST_B_IN,
    input wire logic [1:0]                        REACTIVE_ACCUM_MODE_IN,
    input wire logic [1:0]                        CONNECTION_SELECT_IN,
    input wire logic                              SAMPLE_STROBE_IN,
    input wire logic [REA_PHASES-1:0][REA_DW-1:0] ACTIVE_TOTAL_IN,
    input wire logic [REA_PHASES-1:0][REA_DW-1:0] REACTIVE_TOTAL_IN,
    input wire logic [REA_PHASES-1:0][REA_DW-1:0] CURRENT_IN,
    input wire logic [REA_PHASES-1:0][REA_AW-1:0] ENERGY_REG_TOTAL_OUT,
    input wire logic [REA_PHASES-1:0][REA_AW-1:0] ENERGY_PULSE_OUTPUT_TOTAL_OUT,
    input wire logic [REA_PHASES-1:0][REA_DW-1:0] ACCUM_CURRENT_OUT
);
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // sign extension kept local so a slip in the shared conditioning is not hidden
    function automatic logic [REA_AW-1:0] sx(input logic [REA_DW-1:0] v);
        return {v[REA_DW-1], v};
    endfunction : sx

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    chk_signed_keeps_sign: assert property (SAMPLE_STROBE_IN
        && $past(REACTIVE_ACCUM_MODE_IN) == 2'h0
        |=> ENERGY_REG_TOTAL_OUT[0] == sx($past(REACTIVE_TOTAL_IN[0])))
        else $error("signed mode altered the reactive sample");
    chk_reserved_as_signed: assert property (SAMPLE_STROBE_IN
        && $past(REACTIVE_ACCUM_MODE_IN) == 2'h1
        |=> ENERGY_REG_TOTAL_OUT[2] == sx($past(REACTIVE_TOTAL_IN[2])))
        else $error("reserved mode differs from signed mode");
    chk_actsign_positive: assert property (SAMPLE_STROBE_IN
        && $past(REACTIVE_ACCUM_MODE_IN) == 2'h2 && !ACTIVE_TOTAL_IN[0][REA_DW-1]
        |=> ENERGY_REG_TOTAL_OUT[0] == sx($past(REACTIVE_TOTAL_IN[0])))
        else $error("positive active power changed reactive sign");
    chk_actsign_negative: assert property (SAMPLE_STROBE_IN
        && $past(REACTIVE_ACCUM_MODE_IN) == 2'h2 && ACTIVE_TOTAL_IN[1][REA_DW-1]
        |=> ENERGY_REG_TOTAL_OUT[1] == -sx($past(REACTIVE_TOTAL_IN[1])))
        else $error("negative active power did not invert reactive");
    chk_abs_magnitude: assert property (SAMPLE_STROBE_IN
        && $past(REACTIVE_ACCUM_MODE_IN) == 2'h3
        |=> ENERGY_REG_TOTAL_OUT[2] == ($past(REACTIVE_TOTAL_IN[2][REA_DW-1])
            ? -sx($past(REACTIVE_TOTAL_IN[2])) : sx($past(REACTIVE_TOTAL_IN[2]))))
        else $error("absolute mode gave a wrong magnitude");
    chk_pulse_follows_reg: assert property (
        ENERGY_PULSE_OUTPUT_TOTAL_OUT == ENERGY_REG_TOTAL_OUT)
        else $error("pulse path differs from energy register path");
    chk_wye_current_pass: assert property (SAMPLE_STROBE_IN
        && $past(CONNECTION_SELECT_IN) == 2'h0
        |=> ACCUM_CURRENT_OUT[1] == $past(CURRENT_IN[1]))
        else $error("wye selection dropped phase b current");
    chk_delta_b_zero: assert property (SAMPLE_STROBE_IN
        && $past(CONNECTION_SELECT_IN) == 2'h1 |=> ACCUM_CURRENT_OUT[1] == '0)
        else $error("delta selection kept phase b current");
endmodule : rea_reactive_accum_properties
`default_nettype wire

// ### verilog/rea_dly_if.sv
// carrier between the accumulation logic and its current delay memory
`timescale 1ns/1ps
`default_nettype none
interface rea_dly_if;
    import rea_pkg::*;
    logic                  wr_en;
    logic [REA_DLY_AW-1:0] wr_addr;
    logic [REA_MEM_W-1:0]  wr_data;
    logic [REA_DLY_AW-1:0] rd_addr;
    logic [REA_MEM_W-1:0]  rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : rea_dly_if
`default_nettype wire

// ### verilog/rea_dly_mem.sv
// delay memory for the phase currents, registered read port
`timescale 1ns/1ps
`default_nettype none
module rea_dly_mem
    import rea_pkg::*;
(
    input  wire logic clk_in,
    rea_dly_if.mem    dly
);
    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [REA_MEM_W-1:0] store [0:(1<<REA_DLY_AW)-1];
    logic [REA_MEM_W-1:0] rd_q;

    // no reset on the array: contents are masked downstream until filled
    always_ff @(posedge clk_in)
    begin
        if (dly.wr_en)
        begin
            store[dly.wr_addr] <= dly.wr_data;
        end
        rd_q <= store[dly.rd_addr];
    end

    assign dly.rd_data = rd_q;
endmodule : rea_dly_mem
`default_nettype wire

// ### verilog/rea_pkg.sv
// constants, encodings and sign conditioning shared by the reactive accumulation block
package rea_pkg;
    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int REA_PHASES = 3;
    localparam int REA_DW     = 24;
    localparam int REA_AW     = 25;
    localparam int REA_DLY_AW = 6;
    localparam int REA_MEM_W  = REA_PHASES * REA_DW;

    // ------------------------------------------------------------------
    // field encodings and values after reset
    // ------------------------------------------------------------------
    localparam logic [1:0] REA_MODE_SIGNED  = 2'h0;
    localparam logic [1:0] REA_MODE_RSVD    = 2'h1;
    localparam logic [1:0] REA_MODE_ACTSIGN = 2'h2;
    localparam logic [1:0] REA_MODE_ABS     = 2'h3;
    localparam logic [1:0] REA_MODE_RST     = 2'h0;

    localparam logic [1:0] REA_CONN_WYE4    = 2'h0;
    localparam logic [1:0] REA_CONN_DELTA3  = 2'h1;
    localparam logic [1:0] REA_CONN_RST     = 2'h0;

    // ------------------------------------------------------------------
    // quarter cycle delay, in samples (a 50 Hz line sampled at 8 kHz)
    // ------------------------------------------------------------------
    localparam logic [REA_DLY_AW-1:0] REA_QUARTER_SAMPLES = 6'h28;
    localparam logic [REA_DLY_AW-1:0] REA_PTR_RST         = 6'h00;

    // sign conditioning of one reactive sample; result is one bit wider
    // so that the magnitude of the most negative value does not wrap
    function automatic logic signed [REA_AW-1:0] rea_condition(
        input logic [1:0]               mode,
        input logic signed [REA_DW-1:0] react,
        input logic signed [REA_DW-1:0] act
    );
        logic signed [REA_AW-1:0] ext;
        ext = {react[REA_DW-1], react};
        case (mode)
            REA_MODE_ACTSIGN: rea_condition = act[REA_DW-1] ? -ext : ext;
            REA_MODE_ABS:     rea_condition = ext[REA_AW-1] ? -ext : ext;
            default:          rea_condition = ext;
        endcase
    endfunction : rea_condition
endpackage : rea_pkg

// ### verilog/rea_reactive_accum.sv
// reactive accumulation mode, connection selection and shifted currents
// ----------------------------------------------------------------------
// Summary of operation
// - mode 00 passes total and fundamental reactive power with sign kept
// - reserved mode 01 behaves exactly like signed mode 00
// - mode 10 passes reactive power unchanged when its active power is positive
// - mode 10 inverts reactive power when its active power is negative
// - mode 11 passes the magnitude of reactive power
// - energy registers and energy pulse outputs receive the same conditioned value
// - connection select field chooses which currents feed energy accumulation
// - phase currents are also offered delayed by a quarter cycle
// - connection code 00 is three-phase four-wire with three voltage sensors
// - connection code 01 is three-phase three-wire delta
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module rea_reactive_accum
    import rea_pkg::*;
(
    input  wire logic                               CLK_IN,
    input  wire logic                               RST_B_IN,
    input  wire logic [1:0]                         REACTIVE_ACCUM_MODE_IN,
    input  wire logic [1:0]                         CONNECTION_SELECT_IN,
    input  wire logic                               SAMPLE_STROBE_IN,
    input  wire logic [REA_PHASES-1:0][REA_DW-1:0]  ACTIVE_TOTAL_IN,
    input  wire logic [REA_PHASES-1:0][REA_DW-1:0]  ACTIVE_FUND_IN,
    input  wire logic [REA_PHASES-1:0][REA_DW-1:0]  REACTIVE_TOTAL_IN,
    input  wire logic [REA_PHASES-1:0][REA_DW-1:0]  REACTIVE_FUND_IN,
    input  wire logic [REA_PHASES-1:0][REA_DW-1:0]  CURRENT_IN,
    output var  logic [REA_PHASES-1:0][REA_AW-1:0]  ENERGY_REG_TOTAL_OUT,
    output var  logic [REA_PHASES-1:0][REA_AW-1:0]  ENERGY_REG_FUND_OUT,
    output var  logic [REA_PHASES-1:0][REA_AW-1:0]  ENERGY_PULSE_OUTPUT_TOTAL_OUT,
    output var  logic [REA_PHASES-1:0][REA_AW-1:0]  ENERGY_PULSE_OUTPUT_FUND_OUT,
    output var  logic [REA_PHASES-1:0][REA_DW-1:0]  ACCUM_CURRENT_OUT,
    output var  logic [REA_PHASES-1:0][REA_DW-1:0]  ACCUM_CURRENT_SHIFTED_OUT,
    output var  logic                               ACCUM_VALID_OUT
);
    // ------------------------------------------------------------------
    // configuration holding
    // ------------------------------------------------------------------
    logic [1:0] reactive_accum_mode;
    logic [1:0] connection_select;

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            reactive_accum_mode <= REA_MODE_RST;
            connection_select   <= REA_CONN_RST;
        end
        else
        begin
            reactive_accum_mode <= REACTIVE_ACCUM_MODE_IN;
            connection_select   <= CONNECTION_SELECT_IN;
        end
    end

    // ------------------------------------------------------------------
    // sign conditioning, one value shared by registers and pulses
    // ------------------------------------------------------------------
    logic [REA_PHASES-1:0][REA_AW-1:0] next_total;
    logic [REA_PHASES-1:0][REA_AW-1:0] next_fund;

    genvar ph;
    generate
        for (ph = 0; ph < REA_PHASES; ph++)
        begin : g_cond
            // each quantity looks at its own active power sign
            assign next_total[ph] = rea_condition(reactive_accum_mode,
                                                  REACTIVE_TOTAL_IN[ph],
                                                  ACTIVE_TOTAL_IN[ph]);
            assign next_fund[ph]  = rea_condition(reactive_accum_mode,
                                                  REACTIVE_FUND_IN[ph],
                                                  ACTIVE_FUND_IN[ph]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // quarter cycle current delay
    // ------------------------------------------------------------------
    rea_dly_if dly ();

    logic [REA_DLY_AW-1:0] wr_ptr;
    logic [REA_DLY_AW-1:0] fill_count;
    wire  logic            delay_filled = (fill_count == REA_QUARTER_SAMPLES);

    assign dly.wr_en   = SAMPLE_STROBE_IN;
    assign dly.wr_addr = wr_ptr;
    assign dly.wr_data = CURRENT_IN;
    assign dly.rd_addr = wr_ptr - REA_QUARTER_SAMPLES;

    rea_dly_mem u_dly_mem (
        .clk_in (CLK_IN),
        .dly    (dly.mem)
    );

    logic [REA_DLY_AW-1:0] next_wr_ptr;
    logic [REA_DLY_AW-1:0] next_fill_count;

    // the fill count saturates at the delay depth so the mask never reopens on wrap
    assign next_wr_ptr     = SAMPLE_STROBE_IN ? (wr_ptr + 6'h01) : wr_ptr;
    assign next_fill_count = (SAMPLE_STROBE_IN && !delay_filled) ? (fill_count + 6'h01)
                                                                 : fill_count;

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            wr_ptr <= REA_PTR_RST;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            fill_count <= REA_PTR_RST;
        end
        else
        begin
            fill_count <= next_fill_count;
        end
    end

    // until a quarter cycle of history exists the shifted currents read zero
    wire logic [REA_MEM_W-1:0] shifted_raw = delay_filled ? dly.rd_data : '0;

    // ------------------------------------------------------------------
    // connection selection
    // ------------------------------------------------------------------
    logic [REA_PHASES-1:0][REA_DW-1:0] next_current;
    logic [REA_PHASES-1:0][REA_DW-1:0] next_shifted;

    // delta service has no phase B current path; reserved codes act as 00
    wire logic drop_phase_b = (connection_select == REA_CONN_DELTA3);

    generate
        for (ph = 0; ph < REA_PHASES; ph++)
        begin : g_sel
            wire logic keep = !(drop_phase_b && (ph == 1));
            assign next_current[ph] = keep ? CURRENT_IN[ph] : '0;
            assign next_shifted[ph] = keep ? shifted_raw[ph*REA_DW +: REA_DW] : '0;
        end
    endgenerate

    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------
    logic [REA_PHASES-1:0][REA_AW-1:0] next_energy_total;
    logic [REA_PHASES-1:0][REA_AW-1:0] next_energy_fund;
    logic [REA_PHASES-1:0][REA_DW-1:0] next_accum_current;
    logic [REA_PHASES-1:0][REA_DW-1:0] next_accum_shifted;

    // energy and current outputs hold between strobes so a slow reader still sees the last sample
    assign next_energy_total  = SAMPLE_STROBE_IN ? next_total   : ENERGY_REG_TOTAL_OUT;
    assign next_energy_fund   = SAMPLE_STROBE_IN ? next_fund    : ENERGY_REG_FUND_OUT;
    assign next_accum_current = SAMPLE_STROBE_IN ? next_current : ACCUM_CURRENT_OUT;
    assign next_accum_shifted = SAMPLE_STROBE_IN ? next_shifted : ACCUM_CURRENT_SHIFTED_OUT;

    // pulse path takes the very same conditioned value, so the two never drift
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            ENERGY_REG_TOTAL_OUT          <= '0;
            ENERGY_PULSE_OUTPUT_TOTAL_OUT <= '0;
        end
        else
        begin
            ENERGY_REG_TOTAL_OUT          <= next_energy_total;
            ENERGY_PULSE_OUTPUT_TOTAL_OUT <= next_energy_total;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            ENERGY_REG_FUND_OUT          <= '0;
            ENERGY_PULSE_OUTPUT_FUND_OUT <= '0;
        end
        else
        begin
            ENERGY_REG_FUND_OUT          <= next_energy_fund;
            ENERGY_PULSE_OUTPUT_FUND_OUT <= next_energy_fund;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            ACCUM_CURRENT_OUT <= '0;
        end
        else
        begin
            ACCUM_CURRENT_OUT <= next_accum_current;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            ACCUM_CURRENT_SHIFTED_OUT <= '0;
        end
        else
        begin
            ACCUM_CURRENT_SHIFTED_OUT <= next_accum_shifted;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            ACCUM_VALID_OUT <= 1'h0;
        end
        else
        begin
            ACCUM_VALID_OUT <= SAMPLE_STROBE_IN;
        end
    end
endmodule : rea_reactive_accum
`default_nettype wire
